// ==== src/oss_regs.vh ====
// register map, field positions, reset values and timing constants of the clock switch
`ifndef OSS_REGS_VH
`define OSS_REGS_VH

// byte addresses on the register bus
`define OSS_ADDR_TRIM        8'h38
`define OSS_ADDR_STATUS      8'h3c
`define OSS_ADDR_CONTROL     8'h34

// trim register
`define OSS_TRIM_RESET       8'h80
`define OSS_TRIM_CENTRE      8'h80

// status register fields
`define OSS_ST_ENGAGED_BIT   0
`define OSS_ST_REQUEST_BIT   1

// control register fields
`define OSS_CT_SEL_LSB       0
`define OSS_CT_SEL_MSB       1
`define OSS_CT_AUXEN_BIT     2
`define OSS_CT_SEL_RESET     2'h0
`define OSS_CT_AUXEN_RESET   1'h0

// clock source encodings
`define OSS_SRC_INTERNAL     2'h0
`define OSS_SRC_EXT_CLOCK    2'h1
`define OSS_SRC_EXT_RC       2'h2
`define OSS_SRC_CRYSTAL      2'h3

// rising edges of the external source needed before the hand-off
`define OSS_EXT_EDGES        2'h2

// internal oscillator model: 4.0 MHz nominal from a 25 MHz clock
`define OSS_SYS_CLK_KHZ      25000
`define OSS_INT_FREQ_KHZ     4000
`define OSS_NCO_WIDTH        16
`define OSS_NCO_TRIM_STEP    16'h0015

`endif

// ==== src/oss_sync.v ====
// two-flop synchroniser with a rising-edge pulse for one asynchronous input
`timescale 1ns/1ps
`default_nettype none

module oss_sync
(
   // clock and reset
   input  wire clk_i,
   input  wire rst_n_i,
   // asynchronous input
   input  wire async_i,
   // synchronised level and rising edge
   output wire level_o,
   output wire rise_o
);

   reg meta;
   reg stable;
   reg last;

   // first flop feeds only the second
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta   <= 1'b0;
         stable <= 1'b0;
         last   <= 1'b0;
      end
      else
      begin
         meta   <= async_i;
         stable <= meta;
         last   <= stable;
      end
   end

   assign level_o = stable;
   assign rise_o  = stable & ~last;

endmodule

`default_nettype wire

// ==== src/oss_clock_switch.v ====
// clock source selection, glitch-free switch, trim register and aux pin control
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "oss_regs.vh"

module oss_clock_switch
#(
   parameter NCO_WIDTH = `OSS_NCO_WIDTH
)
(
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_n_i,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // external source clocks, asynchronous
   input  wire        clock_input_pin_i,
   input  wire        rc_osc_clock_i,
   input  wire        crystal_clock_i,
   // system integration unit controls
   input  wire        osc_enable_from_sysint_i,
   input  wire        stop_mode_i,
   input  wire        monitor_bypass_i,
   // port a bit four from the port logic
   input  wire        port_a_bit_four_out_i,
   input  wire        port_a_bit_four_oe_i,
   // derived clocks
   output reg         clock_times_four_o,
   output reg         clock_times_two_o,
   // pin and oscillator controls
   output reg         clock_input_pin_ext_o,
   output reg         crystal_amp_enable_o,
   output reg         rc_osc_enable_o,
   output reg         internal_osc_running_o,
   output reg         clock_aux_pin_out_o,
   output reg         clock_aux_pin_oe_o,
   output reg         clock_aux_pin_crystal_o
);

   // one-hot switch states
   localparam [3:0] ST_INT  = 4'h1;
   localparam [3:0] ST_WAIT = 4'h2;
   localparam [3:0] ST_HAND = 4'h4;
   localparam [3:0] ST_ENG  = 4'h8;

   // nominal nco increment, worked out wide and cut to the accumulator width
   localparam [31:0] NCO_BASE_FULL =
      ((`OSS_INT_FREQ_KHZ * (1 << NCO_WIDTH)) / `OSS_SYS_CLK_KHZ);
   localparam [NCO_WIDTH-1:0] NCO_BASE = NCO_BASE_FULL[NCO_WIDTH-1:0];

   // software-visible state
   reg  [7:0]           internal_osc_trim;
   reg  [1:0]           clock_source_select;
   reg                  aux_pin_clock_out_enable;
   reg                  ext_clock_request;
   reg                  ext_clock_engaged;

   // switch machinery
   reg  [3:0]           state;
   reg  [1:0]           edge_count;
   reg                  src_is_ext;
   reg                  int_run;
   reg  [NCO_WIDTH-1:0] nco_acc;

   // synchronised sources
   wire                 pin_lvl;
   wire                 pin_rise;
   wire                 rc_lvl;
   wire                 rc_rise;
   wire                 xtal_lvl;
   wire                 xtal_rise;

   reg                  ext_lvl;
   reg                  ext_rise;
   wire                 int_lvl;
   wire                 src_lvl;
   wire                 gated_lvl;
   wire                 bus_req;
   wire                 wr_lane0;
   wire [8:0]           trim_off;
   wire [NCO_WIDTH-1:0] nco_inc;

   // one synchroniser per external source
   oss_sync u_sync_pin
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i (clock_input_pin_i),
      .level_o (pin_lvl),
      .rise_o  (pin_rise)
   );

   oss_sync u_sync_rc
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i (rc_osc_clock_i),
      .level_o (rc_lvl),
      .rise_o  (rc_rise)
   );

   oss_sync u_sync_xtal
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i (crystal_clock_i),
      .level_o (xtal_lvl),
      .rise_o  (xtal_rise)
   );

   // pick the external source named by the select field
   always @*
   begin
      ext_lvl  = 1'b0;
      ext_rise = 1'b0;
      case (clock_source_select)
         `OSS_SRC_EXT_CLOCK:
         begin
            ext_lvl  = pin_lvl;
            ext_rise = pin_rise;
         end
         `OSS_SRC_EXT_RC:
         begin
            ext_lvl  = rc_lvl;
            ext_rise = rc_rise;
         end
         `OSS_SRC_CRYSTAL:
         begin
            ext_lvl  = xtal_lvl;
            ext_rise = xtal_rise;
         end
         default:
         begin
            ext_lvl  = 1'b0;
            ext_rise = 1'b0;
         end
      endcase
   end

   // trim offset around the centre; a larger trim slows the nco
   assign trim_off = {1'b0, internal_osc_trim} - {1'b0, `OSS_TRIM_CENTRE};
   assign nco_inc  = NCO_BASE - ({{(NCO_WIDTH-9){trim_off[8]}}, trim_off}
                     * `OSS_NCO_TRIM_STEP);

   // internal oscillator as a phase accumulator, halted once external is engaged
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         nco_acc <= {NCO_WIDTH{1'b0}};
      else if (int_run && osc_enable_from_sysint_i && !stop_mode_i)
         nco_acc <= nco_acc + nco_inc;
   end

   assign int_lvl   = nco_acc[NCO_WIDTH-1];
   assign src_lvl   = src_is_ext ? ext_lvl : int_lvl;
   // wait and break have no say here, only enable and stop
   assign gated_lvl = src_lvl & osc_enable_from_sysint_i & ~stop_mode_i;

   // derived clocks: times-four follows the source, times-two halves it
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         clock_times_four_o <= 1'b0;
         clock_times_two_o  <= 1'b0;
      end
      else
      begin
         clock_times_four_o <= gated_lvl;
         if (gated_lvl && !clock_times_four_o)
            clock_times_two_o <= ~clock_times_two_o;
      end
   end

   // switch sequencer from internal to external source
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state             <= ST_INT;
         edge_count        <= 2'h0;
         src_is_ext        <= 1'b0;
         int_run           <= 1'b1;
         ext_clock_engaged <= 1'b0;
      end
      else
      begin
         case (state)
            ST_INT:
            begin
               edge_count <= 2'h0;
               if (ext_clock_request && !monitor_bypass_i &&
                   clock_source_select != `OSS_SRC_INTERNAL)
                  state <= ST_WAIT;
            end
            ST_WAIT:
            begin
               if (!ext_clock_request)
                  state <= ST_INT;
               else if (ext_rise)
               begin
                  if (edge_count == `OSS_EXT_EDGES - 2'h1)
                     state <= ST_HAND;
                  edge_count <= edge_count + 2'h1;
               end
            end
            ST_HAND:
            begin
               // both clocks low: no shortened pulse at the seam
               if (!int_lvl && !ext_lvl)
               begin
                  src_is_ext        <= 1'b1;
                  ext_clock_engaged <= 1'b1;
                  state             <= ST_ENG;
               end
            end
            ST_ENG:
            begin
               int_run <= 1'b0;
            end
            default:
               state <= ST_INT;
         endcase
      end
   end

   // register bus request and byte lane for the narrow registers
   assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];

   // register writes and bus answer
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         internal_osc_trim        <= `OSS_TRIM_RESET;
         clock_source_select      <= `OSS_CT_SEL_RESET;
         aux_pin_clock_out_enable <= `OSS_CT_AUXEN_RESET;
         ext_clock_request        <= 1'b0;
         wb_ack_o                 <= 1'b0;
         wb_dat_o                 <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= bus_req;
         wb_dat_o <= 32'h0000_0000;
         if (bus_req && !wb_we_i)
         begin
            if (wb_adr_i == `OSS_ADDR_TRIM)
               wb_dat_o <= {24'h00_0000, internal_osc_trim};
            else if (wb_adr_i == `OSS_ADDR_STATUS)
               wb_dat_o <= {30'h0000_0000, ext_clock_request, ext_clock_engaged};
            else if (wb_adr_i == `OSS_ADDR_CONTROL)
               wb_dat_o <= {29'h0000_0000, aux_pin_clock_out_enable,
                            clock_source_select};
         end
         if (wr_lane0)
         begin
            if (wb_adr_i == `OSS_ADDR_TRIM)
               internal_osc_trim <= wb_dat_i[7:0];
            else if (wb_adr_i == `OSS_ADDR_STATUS)
               ext_clock_request <= wb_dat_i[`OSS_ST_REQUEST_BIT];
            else if (wb_adr_i == `OSS_ADDR_CONTROL)
            begin
               // source frozen once the switch has started
               if (state == ST_INT)
                  clock_source_select <= wb_dat_i[`OSS_CT_SEL_MSB:`OSS_CT_SEL_LSB];
               aux_pin_clock_out_enable <= wb_dat_i[`OSS_CT_AUXEN_BIT];
            end
         end
      end
   end

   // pin functions and oscillator enables follow the select field
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         clock_input_pin_ext_o   <= 1'b0;
         crystal_amp_enable_o    <= 1'b0;
         rc_osc_enable_o         <= 1'b0;
         internal_osc_running_o  <= 1'b0;
         clock_aux_pin_out_o     <= 1'b0;
         clock_aux_pin_oe_o      <= 1'b0;
         clock_aux_pin_crystal_o <= 1'b0;
      end
      else
      begin
         clock_input_pin_ext_o  <= (clock_source_select != `OSS_SRC_INTERNAL);
         crystal_amp_enable_o   <= (clock_source_select == `OSS_SRC_CRYSTAL) &&
                                   osc_enable_from_sysint_i && !stop_mode_i;
         rc_osc_enable_o        <= (clock_source_select == `OSS_SRC_EXT_RC) &&
                                   osc_enable_from_sysint_i && !stop_mode_i;
         internal_osc_running_o <= int_run && osc_enable_from_sysint_i &&
                                   !stop_mode_i;
         if (clock_source_select == `OSS_SRC_CRYSTAL)
         begin
            // amplifier owns the pin, enable bit ignored
            clock_aux_pin_crystal_o <= 1'b1;
            clock_aux_pin_out_o     <= 1'b0;
            clock_aux_pin_oe_o      <= 1'b0;
         end
         else if (clock_source_select == `OSS_SRC_EXT_CLOCK)
         begin
            clock_aux_pin_crystal_o <= 1'b0;
            clock_aux_pin_out_o     <= port_a_bit_four_out_i;
            clock_aux_pin_oe_o      <= port_a_bit_four_oe_i;
         end
         else if (aux_pin_clock_out_enable)
         begin
            clock_aux_pin_crystal_o <= 1'b0;
            clock_aux_pin_out_o     <= gated_lvl;
            clock_aux_pin_oe_o      <= 1'b1;
         end
         else
         begin
            clock_aux_pin_crystal_o <= 1'b0;
            clock_aux_pin_out_o     <= port_a_bit_four_out_i;
            clock_aux_pin_oe_o      <= port_a_bit_four_oe_i;
         end
      end
   end

endmodule

`default_nettype wire

// ==== tb/oss_clock_switch_properties.sv ====
// port assertions for the clock source switch
`timescale 1ns/1ps
`default_nettype none
module oss_clock_switch_props
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // bus
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        wb_ack_o,
   // unit controls
   input  wire logic        osc_enable_from_sysint_i,
   input  wire logic        stop_mode_i,
   // clocks and pin controls
   input  wire logic        clock_times_four_o,
   input  wire logic        clock_times_two_o,
   input  wire logic        clock_input_pin_ext_o,
   input  wire logic        crystal_amp_enable_o,
   input  wire logic        rc_osc_enable_o,
   input  wire logic        internal_osc_running_o,
   input  wire logic        clock_aux_pin_oe_o,
   input  wire logic        clock_aux_pin_crystal_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // request taken, and stop held long enough to settle
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_stop3;
      stop_mode_i[*3];
   endsequence
   property p_ack_next;
      s_take |=> wb_ack_o;
   endproperty
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_dat_idle;
      !wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   property p_xtal_gate;
      crystal_amp_enable_o |-> $past(osc_enable_from_sysint_i) && !$past(stop_mode_i);
   endproperty
   property p_rc_gate;
      rc_osc_enable_o |-> $past(osc_enable_from_sysint_i) && !$past(stop_mode_i);
   endproperty
   property p_int_gate;
      internal_osc_running_o |-> $past(osc_enable_from_sysint_i) && !$past(stop_mode_i);
   endproperty
   property p_stop_low;
      s_stop3 |-> !clock_times_four_o && !internal_osc_running_o;
   endproperty
   property p_half;
      $changed(clock_times_two_o) |-> $rose(clock_times_four_o);
   endproperty
   property p_half_rise;
      $rose(clock_times_four_o) |-> $changed(clock_times_two_o);
   endproperty
   property p_xtal_aux;
      clock_aux_pin_crystal_o |-> !clock_aux_pin_oe_o && clock_input_pin_ext_o;
   endproperty
   property p_pin_ext;
      $rose(clock_input_pin_ext_o) |-> $past(wb_ack_o && wb_we_i);
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   a_dat_idle: assert property (p_dat_idle) else $error("read data not idle");
   a_xtal_gate: assert property (p_xtal_gate) else $error("crystal on ungated");
   a_rc_gate: assert property (p_rc_gate) else $error("rc on ungated");
   a_int_gate: assert property (p_int_gate) else $error("internal on ungated");
   a_stop_low: assert property (p_stop_low) else $error("clock in stop");
   a_half: assert property (p_half) else $error("x2 moved off x4 rise");
   a_half_rise: assert property (p_half_rise) else $error("x2 missed x4 rise");
   a_xtal_aux: assert property (p_xtal_aux) else $error("aux pin in crystal");
   a_pin_ext: assert property (p_pin_ext) else $error("pin mode w/o write");
endmodule
bind oss_clock_switch oss_clock_switch_props oss_clock_switch_props_i (.*);
`default_nettype wire

// ==== tb/oss_sysint_model.sv ====
// system integration unit model: enable, stop and source clock
`timescale 1ns/1ps
`default_nettype none
module oss_sysint_model
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // scenario controls
   input  wire logic run_i,
   input  wire logic stop_req_i,
   // clock taken from the switch
   input  wire logic x4_i,
   // towards the switch, and the x4 rise count for the rate checks
   output var logic  ext_clk_o,
   output var logic  osc_en_o,
   output var logic  stop_o,
   output var int    x4_rises_o
);
   // source clock stands low whenever not running
   initial
   begin
      ext_clk_o = 1'b0;
      #7;
      forever #160 ext_clk_o = run_i & ~ext_clk_o;
   end
   // enable after reset, stop on request
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         osc_en_o <= 1'b0;
         stop_o   <= 1'b0;
      end
      else
      begin
         osc_en_o <= 1'b1;
         stop_o   <= stop_req_i;
      end
   end
   // rate checks count x4 rising edges
   initial x4_rises_o = 0;
   always @(posedge x4_i) x4_rises_o <= x4_rises_o + 1;
endmodule
`default_nettype wire

// ==== tb/oss_clock_switch_tb.sv ====
// self-checking bench for the clock source switch
`timescale 1ns/1ps
`default_nettype none
module oss_clock_switch_tb;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        bypass = 1'b0;
   logic        run = 1'b0;
   logic        stop_req = 1'b0;
   logic        pa_oe = 1'b0;
   logic        ack, ext_clk, osc_en, stop, x4, x2, pin_ext;
   logic        xtal_en, rc_en, int_run, aux_out, aux_oe, aux_xtal;
   logic [7:0]  q;
   int          bad_count = 0;
   int          n_compared = 0;
   int          ext_n = 0;
   int          rises, r0, e0, i;
   // clock and source edge count
   always #20 clk_i = ~clk_i;
   always @(posedge ext_clk) ext_n++;
   oss_clock_switch oss_clock_switch_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .clock_input_pin_i(ext_clk), .rc_osc_clock_i(ext_clk),
      .crystal_clock_i(ext_clk), .osc_enable_from_sysint_i(osc_en), .stop_mode_i(stop),
      .monitor_bypass_i(bypass), .port_a_bit_four_out_i(1'b1), .port_a_bit_four_oe_i(pa_oe),
      .clock_times_four_o(x4), .clock_times_two_o(x2), .clock_input_pin_ext_o(pin_ext),
      .crystal_amp_enable_o(xtal_en), .rc_osc_enable_o(rc_en),
      .internal_osc_running_o(int_run), .clock_aux_pin_out_o(aux_out),
      .clock_aux_pin_oe_o(aux_oe), .clock_aux_pin_crystal_o(aux_xtal));
   oss_sysint_model oss_sysint_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run),
      .stop_req_i(stop_req), .x4_i(x4), .ext_clk_o(ext_clk), .osc_en_o(osc_en),
      .stop_o(stop), .x4_rises_o(rises));
   // compare, bus and edge-count helpers
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      chk("ack_wait", 8'h02, n[7:0]);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      bus(a, 1'b0, 8'h00);
      chk(what, exp, q);
   endtask
   task automatic count(input int n);
      r0 = rises;
      e0 = ext_n;
      repeat (n) @(posedge clk_i);
      r0 = rises - r0;
      e0 = ext_n - e0;
   endtask
   // scenarios
   task automatic t_reset;
      rd(8'h38, 8'h80, "trim");
      rd(8'h3c, 8'h00, "status");
      rd(8'h34, 8'h00, "control");
      rd(8'h10, 8'h00, "unmapped");
      bus(8'h38, 1'b1, 8'h7a);
      rd(8'h38, 8'h7a, "factory_trim");
   endtask
   task automatic t_trim;
      int base;
      count(250);
      base = r0;
      chk("int_rate", 8'h01, {7'h0, base >= 36 && base <= 44});
      bus(8'h38, 1'b1, 8'hff);
      rd(8'h38, 8'hff, "trim_rw");
      count(250);
      chk("trim_slows", 8'h01, {7'h0, r0 < base});
      bus(8'h38, 1'b1, 8'h80);
   endtask
   task automatic t_stop;
      stop_req <= 1'b1;
      repeat (4) @(posedge clk_i);
      count(100);
      chk("stop_x4", 8'h00, r0[7:0]);
      chk("stop_int", 8'h00, {7'h0, int_run});
      stop_req <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("int_back", 8'h01, {7'h0, int_run});
   endtask
   task automatic t_aux;
      bus(8'h34, 1'b1, 8'h04);
      repeat (3) @(posedge clk_i);
      chk("aux_int", 8'h01, {7'h0, aux_oe});
      // port drives the aux pin high before crystal mode
      bus(8'h34, 1'b1, 8'h00);
      pa_oe <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk("precharge", 8'h03, {6'h0, aux_out, aux_oe});
      bus(8'h34, 1'b1, 8'h07);
      repeat (3) @(posedge clk_i);
      chk("xtal_mode", 8'h0d, {3'h0, aux_out, xtal_en, aux_xtal, aux_oe, pin_ext});
      pa_oe <= 1'b0;
      bus(8'h34, 1'b1, 8'h05);
      repeat (3) @(posedge clk_i);
      chk("ext_mode", 8'h11, {3'h0, aux_out, xtal_en, aux_xtal, aux_oe, pin_ext});
   endtask
   task automatic t_switch;
      run <= 1'b1;
      bypass <= 1'b1;
      repeat (100) @(posedge clk_i);
      bus(8'h3c, 1'b1, 8'h02);
      repeat (100) @(posedge clk_i);
      rd(8'h3c, 8'h02, "bypassed");
      bypass <= 1'b0;
      for (i = 0; i < 40 && q !== 8'h03; i++) bus(8'h3c, 1'b0, 8'h00);
      chk("engaged", 8'h03, q);
      // internal stop reaches the registered output two edges later
      repeat (2) @(posedge clk_i);
      chk("int_off", 8'h00, {7'h0, int_run});
      count(400);
      chk("x4_follows", 8'h01, {7'h0, r0 - e0 <= 1 && e0 - r0 <= 1});
      bus(8'h3c, 1'b1, 8'h00);
      rd(8'h3c, 8'h01, "stays");
      run <= 1'b0;
      // let edges already in the synchroniser drain
      repeat (8) @(posedge clk_i);
      count(200);
      chk("no_fallback", 8'h00, r0[7:0]);
      chk("int_stays", 8'h00, {7'h0, int_run});
      // only a reset brings the internal oscillator back
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("int_restart", 8'h01, {7'h0, int_run});
      rd(8'h3c, 8'h00, "status_rst");
      rd(8'h38, 8'h80, "trim_rst");
      rd(8'h34, 8'h00, "control_rst");
   endtask
   task automatic finish_test;
      $display("compared %0d bad %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_trim();
      t_stop();
      t_aux();
      t_switch();
      finish_test();
   end
   // watchdog
   initial
   begin
      #400000;
      bad_count++;
      finish_test();
   end
endmodule
`default_nettype wire
